// ---- rtl/ddspa_core.sv ----
// Purpose: Direct digital synthesis core: accumulator, waveform RAM, DAC code
// Assumes: core_clk_in is the constant sample clock; loader is on the same clock
// Notes:   Frequency changes only through the phase step word
`timescale 1ns/1ns
`default_nettype none
module ddspa_core
    import ddspa_pkg::*;
#(
    parameter int AW = ACC_W,
    parameter int RW = ADDR_W,
    parameter int DW = SAMPLE_W
) (
    input  wire logic          core_clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          clk_en_in,
    input  wire logic [AW-1:0] phase_step_word_in,
    input  wire logic          step_load_in,
    input  wire ddspa_wr_s     wave_wr_in,
    input  wire logic [RW-1:0] wave_len_in,
    input  wire logic          len_load_in,
    input  wire ddspa_func_e   func_sel_in,
    output logic      [DW-1:0] dac_code_out,
    output logic      [1:0]    filter_sel_out,
    output logic      [RW-1:0] ram_addr_out,
    output logic               wr_reject_out
);
    logic [AW-1:0] step_r;
    logic [AW-1:0] acc;
    logic [RW-1:0] len_r;
    logic [RW-1:0] rd_addr;
    logic [RW-1:0] wr_idx;
    logic [DW-1:0] rd_data;
    logic [31:0]   scaled;
    logic          wr_ok;
    logic          len_ok;

    // Step word register: accumulator keeps its value, the new step counts
    // from the following edge, so the phase is continuous
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            step_r <= '0;
        end else if (clk_en_in && step_load_in) begin
            step_r <= phase_step_word_in;
        end
    end

    // 48-bit accumulator on the fixed sample clock
    ddspa_phase_acc #(
        .W (AW)
    ) u_acc (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .clk_en_in   (clk_en_in),
        .step_in     (step_r),
        .acc_out     (acc)
    );

    // Length must stay inside the legal window; bad loads are dropped
    assign len_ok = (wave_len_in >= LEN_MIN) && (wave_len_in <= LEN_MAX);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            len_r <= LEN_RST;
        end else if (clk_en_in && len_load_in && len_ok) begin
            len_r <= wave_len_in;
        end
    end

    // Top 14 phase bits scaled to the stored length, so one full
    // accumulator turn covers exactly the points loaded; with the
    // full table the scaling is close to identity. Small steps then
    // walk every address and large steps skip some.
    assign scaled  = 32'(acc[AW-1 -: RW]) * 32'(len_r);
    assign rd_addr = scaled[RW +: RW];

    // Writes past the largest legal table are refused; the current
    // length is not used, so a longer table can be loaded before it
    assign wr_ok = wave_wr_in.we && (wave_wr_in.addr < LEN_MAX);
    assign wr_idx = wave_wr_in.addr;

    ddspa_wave_ram #(
        .DEPTH (RAM_DEPTH),
        .AW    (RW),
        .DW    (DW)
    ) u_ram (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .clk_en_in   (clk_en_in),
        .wr_en_in    (wr_ok),
        .wr_addr_in  (wr_idx),
        .wr_data_in  (wave_wr_in.data),
        .rd_addr_in  (rd_addr),
        .rd_data_out (rd_data)
    );

    // Address shown for debug, registered to keep outputs glitch-free
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ram_addr_out <= '0;
        end else if (clk_en_in) begin
            ram_addr_out <= rd_addr;
        end
    end

    // Full 12-bit code straight to the DAC, no scaling that would lose codes
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dac_code_out <= SAMPLE_RST;
        end else if (clk_en_in) begin
            dac_code_out <= rd_data;
        end
    end

    // Filter path follows the selected function
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            filter_sel_out <= DDSPA_FLT_ELLIPTIC;
        end else if (clk_en_in) begin
            case (func_sel_in)
                DDSPA_FN_SINE: filter_sel_out <= DDSPA_FLT_ELLIPTIC;
                default:       filter_sel_out <= DDSPA_FLT_BESSEL;
            endcase
        end
    end

    // Flag for a refused write or length load, one cycle
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_reject_out <= 1'b0;
        end else if (clk_en_in) begin
            wr_reject_out <= (wave_wr_in.we && !wr_ok) || (len_load_in && !len_ok);
        end
    end
endmodule : ddspa_core
`default_nettype wire

// ---- rtl/ddspa_pkg.sv ----
// Purpose: Shared constants and types for the phase accumulator core
// Assumes: One sample clock; no software-visible registers
// Notes:   Widths and limits are named once here
package ddspa_pkg;
    localparam int          ACC_W          = 48;            // Accumulator width
    localparam int          ADDR_W         = 14;            // Waveform RAM address width
    localparam int          SAMPLE_W       = 12;            // DAC code width
    localparam int          RAM_DEPTH      = 16384;         // 2**ADDR_W locations
    localparam logic [13:0] LEN_MIN        = 14'h0008;      // Fewest points per cycle
    localparam logic [13:0] LEN_MAX        = 14'h3E80;      // Most points per cycle
    localparam logic [47:0] ACC_RST        = 48'h000000000000;
    localparam logic [11:0] SAMPLE_RST     = 12'h000;
    localparam logic [13:0] LEN_RST        = 14'h3E80;
    localparam int          SAMPLE_CLK_MHZ = 40;            // Fixed sample rate

    typedef enum logic [2:0] {
        DDSPA_FN_SINE   = 3'b000,
        DDSPA_FN_SQUARE = 3'b001,
        DDSPA_FN_TRI    = 3'b010,
        DDSPA_FN_RAMP   = 3'b011,
        DDSPA_FN_NOISE  = 3'b100,
        DDSPA_FN_USER   = 3'b101
    } ddspa_func_e;

    typedef enum logic [1:0] {
        DDSPA_FLT_ELLIPTIC = 2'b01,   // Sharp 17 MHz path
        DDSPA_FLT_BESSEL   = 2'b10    // Linear-phase 10 MHz path
    } ddspa_filt_e;

    // One waveform RAM write from the loader
    typedef struct packed {
        logic                    we;
        logic [ADDR_W-1:0]       addr;
        logic [SAMPLE_W-1:0]     data;
    } ddspa_wr_s;
endpackage : ddspa_pkg

// ---- rtl/ddspa_wave_ram.sv ----
// Purpose: Waveform sample storage, one write and one registered read port
// Assumes: Loader writes one full cycle at rising addresses
// Notes:   Flip-flop storage; read data lags the address by one cycle
`timescale 1ns/1ns
`default_nettype none
module ddspa_wave_ram
    import ddspa_pkg::*;
#(
    parameter int DEPTH = RAM_DEPTH,
    parameter int AW    = ADDR_W,
    parameter int DW    = SAMPLE_W
) (
    input  wire logic          core_clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          clk_en_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [DW-1:0] wr_data_in,
    input  wire logic [AW-1:0] rd_addr_in,
    output logic      [DW-1:0] rd_data_out
);
    logic [DW-1:0] mem_r [DEPTH];

    // Storage has no reset; contents are defined by the loader
    always_ff @(posedge core_clk_in) begin
        if (clk_en_in && wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
    end

    // Registered read keeps the DAC path free of address glitches
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= '0;
        end else if (clk_en_in) begin
            rd_data_out <= mem_r[rd_addr_in];
        end
    end
endmodule : ddspa_wave_ram
`default_nettype wire

// ---- rtl/ddspa_phase_acc.sv ----
// Purpose: Phase accumulator with modulo wrap
// Assumes: Step word comes from logic on the same clock
// Notes:   Carry out of the top bit is dropped on purpose
`timescale 1ns/1ns
`default_nettype none
module ddspa_phase_acc
    import ddspa_pkg::*;
#(
    parameter int W = ACC_W
) (
    input  wire logic         core_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         clk_en_in,
    input  wire logic [W-1:0] step_in,
    output logic      [W-1:0] acc_out
);
    logic [W-1:0] acc_nxt;

    // Sum is W bits wide, so overflow wraps naturally
    assign acc_nxt = acc_out + step_in;

    // Accumulate on every enabled sample clock; reset starts at phase zero
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_out <= W'(ACC_RST);
        end else if (clk_en_in) begin
            acc_out <= acc_nxt;
        end
    end
endmodule : ddspa_phase_acc
`default_nettype wire

// ---- tb/ddspa_core_asserts.sv ----
// Purpose: Port checks for the synthesis core
// Assumes: One clock; filter and refusal land one enabled edge later
// Notes:   Bound to every core instance
`timescale 1ns/1ns
`default_nettype none
module ddspa_core_asserts
    import ddspa_pkg::*;
(
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic        clk_en_in,
    input wire ddspa_wr_s   wave_wr_in,
    input wire logic [13:0] wave_len_in,
    input wire logic        len_load_in,
    input wire ddspa_func_e func_sel_in,
    input wire logic [11:0] dac_code_out,
    input wire logic [1:0]  filter_sel_out,
    input wire logic [13:0] ram_addr_out,
    input wire logic        wr_reject_out
);
    logic bad_len;
    logic bad_wr;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Requests the core must refuse
    assign bad_len = clk_en_in && len_load_in && (wave_len_in < LEN_MIN || wave_len_in > LEN_MAX);
    assign bad_wr  = clk_en_in && wave_wr_in.we && wave_wr_in.addr >= LEN_MAX;
    sequence s_bad_len;
        bad_len;
    endsequence
    sequence s_bad_wr;
        bad_wr;
    endsequence
    sequence s_ran_on(logic f);
        $past(rst_n_in) && $past(clk_en_in) && f;
    endsequence
    a_reject_len: assert property (s_bad_len |=> wr_reject_out)
        else $error("bad length not refused");
    a_reject_wr: assert property (s_bad_wr |=> wr_reject_out)
        else $error("bad write not refused");
    a_reject_cause: assert property (wr_reject_out && $past(clk_en_in) |-> $past(bad_len || bad_wr))
        else $error("refusal without cause");
    a_filter_sine: assert property (s_ran_on($past(func_sel_in) == DDSPA_FN_SINE) |-> filter_sel_out == DDSPA_FLT_ELLIPTIC)
        else $error("sine not on sharp filter");
    a_filter_other: assert property (s_ran_on($past(func_sel_in) != DDSPA_FN_SINE) |-> filter_sel_out == DDSPA_FLT_BESSEL)
        else $error("other function not on linear filter");
    a_addr_span: assert property (ram_addr_out < LEN_MAX)
        else $error("read address past table");
    a_reset_clear: assert property ($rose(rst_n_in) |-> ram_addr_out == 14'h0000 && dac_code_out == SAMPLE_RST)
        else $error("reset did not clear phase");
    a_hold_idle: assert property ($past(rst_n_in) && !$past(clk_en_in) |-> $stable(dac_code_out) && $stable(ram_addr_out))
        else $error("output moved without sample clock");
endmodule : ddspa_core_asserts
bind ddspa_core ddspa_core_asserts chk_u (.core_clk_in, .rst_n_in, .clk_en_in, .wave_wr_in,
    .wave_len_in, .len_load_in, .func_sel_in, .dac_code_out, .filter_sel_out, .ram_addr_out,
    .wr_reject_out);
`default_nettype wire

// ---- tb/ddspa_dac_model.sv ----
// Purpose: Converter and filter stand-in at the far side
// Assumes: Core drives registered code and filter path
// Notes:   No analog behaviour, one sample latched per clock
`timescale 1ns/1ns
`default_nettype none
module ddspa_dac_model
    import ddspa_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic [11:0] code_in,
    input  wire logic [1:0]  filt_in,
    output logic      [11:0] level_out,
    output logic             sharp_out
);
    // Converter takes every code on the fixed sample clock
    always_ff @(posedge core_clk_in) begin
        level_out <= code_in;
        sharp_out <= filt_in == DDSPA_FLT_ELLIPTIC;
    end
endmodule : ddspa_dac_model
`default_nettype wire

// ---- tb/ddspa_core_tb.sv ----
// Purpose: Self-checking bench for the synthesis core
// Assumes: Inputs change on the falling edge
// Notes:   Eight-point table makes strides easy to predict
`timescale 1ns/1ns
`default_nettype none
module ddspa_core_tb
    import ddspa_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, step_load = 1'b0, len_load = 1'b0;
    logic [47:0] step = 48'h0;
    logic [13:0] len = LEN_MAX;
    ddspa_wr_s   wr = '0;
    ddspa_func_e func = DDSPA_FN_SINE;
    logic [11:0] dac, level;
    logic [13:0] addr;
    logic [1:0]  filt;
    logic        rej, sharp;
    int          errors = 0, total_checks = 0;
    always #25 clk = ~clk;
    ddspa_core dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
        .phase_step_word_in(step), .step_load_in(step_load), .wave_wr_in(wr),
        .wave_len_in(len), .len_load_in(len_load), .func_sel_in(func), .dac_code_out(dac),
        .filter_sel_out(filt), .ram_addr_out(addr), .wr_reject_out(rej));
    ddspa_dac_model dac_u (.core_clk_in(clk), .code_in(dac), .filt_in(filt),
        .level_out(level), .sharp_out(sharp));
    task automatic chk(input string what, input logic [15:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic complete_run;
        if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    // Outputs straight after reset release
    task automatic t_reset;
        chk("addr", 16'h0000, {2'h0, addr});
        chk("filter", 16'h0001, {14'h0, filt});
        // Step is zero after reset, so a cleared accumulator keeps address zero
        repeat (2) @(negedge clk);
        chk("phase_zero", 16'h0000, {2'h0, addr});
    endtask : t_reset
    // Every function code, sine alone on the sharp path
    task automatic t_filter;
        for (int f = 0; f < 6; f++) begin
            func = ddspa_func_e'(3'(f));
            repeat (3) @(negedge clk);
            chk("sharp", 16'(f == 0), {15'h0, sharp});
        end
    endtask : t_filter
    // Shortest legal table, full code swing, rising addresses
    task automatic t_load;
        logic bad;
        bad = 1'b0;
        // Codes run from 0 to 4095; top three bits equal the index
        for (int i = 0; i < 8; i++) begin
            wr = '{1'b1, 14'(i), 12'(i * 585)};
            @(negedge clk);
            bad = bad | rej;
        end
        wr.we = 1'b0;
        len = LEN_MIN;
        len_load = 1'b1;
        @(negedge clk);
        bad = bad | rej;
        len_load = 1'b0;
        chk("accept", 16'h0000, {15'h0, bad});
    endtask : t_load
    // Refused write or length must pulse the reject flag
    task automatic t_refuse(input logic w, input logic [13:0] v);
        logic seen;
        seen = 1'b0;
        wr = '{w, v, 12'h000};
        len = v;
        len_load = !w;
        @(negedge clk);
        wr.we = 1'b0;
        len_load = 1'b0;
        repeat (2) begin
            seen = seen | rej;
            @(negedge clk);
        end
        chk("reject", 16'h0001, {15'h0, seen});
    endtask : t_refuse
    // Table index stride per sample; old or new stride only while the step changes
    task automatic t_sweep(input logic [47:0] s, input logic [2:0] d, old);
        logic [2:0] pv, dl;
        step = s;
        step_load = 1'b1;
        pv = level[11:9];
        @(negedge clk);
        step_load = 1'b0;
        for (int n = 0; n < 20; n++) begin
            @(negedge clk);
            dl = level[11:9] - pv;
            if (n < 8) chk("phase", 16'h0001, 16'(dl == d || dl == old));
            else chk("stride", {13'h0, d}, {13'h0, dl});
            pv = level[11:9];
        end
    endtask : t_sweep
    // Without enabled edges the samples must not move
    task automatic t_idle;
        logic [11:0] v;
        clk_en = 1'b0;
        @(negedge clk);
        v = level;
        repeat (4) @(negedge clk);
        chk("frozen", {4'h0, v}, {4'h0, level});
        clk_en = 1'b1;
    endtask : t_idle
    // Main sequence, second reset mid-run
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_filter();
        t_load();
        t_refuse(1'b1, LEN_MAX);
        t_refuse(1'b0, 14'h0007);
        t_refuse(1'b0, 14'h3E81);
        t_sweep(48'h200000000000, 3'h1, 3'h0);
        t_sweep(48'h400000000000, 3'h2, 3'h1);
        t_sweep(48'h800000000000, 3'h4, 3'h2);
        t_idle();
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        complete_run();
    end
    // About 115 cycles expected; limit set well above
    initial begin
        #20000;
        errors++;
        complete_run();
    end
endmodule : ddspa_core_tb
`default_nettype wire
